// ---- dli_status.sv ----
// module: link initiator control, timeout and error status with apb slave
`timescale 1ns/1ps
`default_nettype none
module dli_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic txn_req,
  input wire dli_pkg::dli_link_in_t link_in,
  output logic link_clock_pin,
  output logic idle_cmd_sent,
  output logic txn_done,
  output logic initiator_active,
  output logic cpu_irq
);

  // ==========================================================
  // declarations
  dli_pkg::dli_link_in_t sync1_ff;
  dli_pkg::dli_link_in_t sync2_ff;
  dli_pkg::dli_state_t state_ff;
  dli_pkg::dli_state_t nxt_state;
  logic [1:0] div_ff;
  logic link_clock_ff;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic link_enable_ff;
  logic ext_irq_enable_ff;
  logic [3:0] ack_wait_limit_ff;
  logic error_summary_flag_ff;
  logic ack_line_fault_flag_ff;
  logic cancel_flag_ff;
  logic wait_expired_flag_ff;
  logic target_error_flag_ff;
  logic parity_fault_flag_ff;
  logic [1:0] received_par_ff;
  logic idle_cmd_ff;
  logic done_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  // ==========================================================
  // apb decode
  wire logic [5:0] reg_idx;
  wire logic addr_ok;
  wire logic idx_hit;
  wire logic acc_phase;
  wire logic wr_acc;
  wire logic rd_acc;
  wire logic wr_lo;
  wire logic sel_ctl0;
  wire logic sel_ctl1;
  wire logic sel_stat0;
  wire logic sel_stat1;

  // word-aligned address, index is the byte address over four
  assign reg_idx = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'h0);
  assign sel_ctl0 = addr_ok && ({2'h0, reg_idx} == dli_pkg::IDX_CTL0);
  assign sel_ctl1 = addr_ok && ({2'h0, reg_idx} == dli_pkg::IDX_CTL1);
  assign sel_stat0 = addr_ok && ({2'h0, reg_idx} == dli_pkg::IDX_STAT0);
  assign sel_stat1 = addr_ok && ({2'h0, reg_idx} == dli_pkg::IDX_STAT1);
  assign idx_hit = sel_ctl0 | sel_ctl1 | sel_stat0 | sel_stat1;
  assign acc_phase = psel && penable;
  assign wr_acc = acc_phase && pwrite && idx_hit;
  assign rd_acc = acc_phase && !pwrite;
  assign wr_lo = wr_acc && pstrb[0];

  // ==========================================================
  // write-once protection
  wire logic cfg_open;

  // writable before enable or at any time in special modes
  assign cfg_open = special_mode || !link_enable_ff; // [RULE_05] [RULE_19]

  // ==========================================================
  // link clock and sampling point
  wire logic link_tick;

  // tick comes two bus clocks before the rising edge of the outgoing link clock
  assign link_tick = (div_ff == dli_pkg::LINK_DIV_M1);

  // ==========================================================
  // acknowledge cycle evaluation
  wire logic in_wait;
  wire logic ack_seen;
  wire logic data_bad;
  wire logic par_bad;
  wire logic expired;
  wire logic start_ok;
  wire logic start_cancel;
  wire logic [1:0] par_expect;

  assign in_wait = (state_ff == dli_pkg::ST_WAIT) && link_tick;
  assign ack_seen = in_wait && sync2_ff.ack;
  // broken-wire check: every data line must read high at acknowledge
  assign data_bad = ack_seen && !(&sync2_ff.data); // [RULE_09]
  assign par_expect = {^sync2_ff.data[7:4], ^sync2_ff.data[3:0]};
  assign par_bad = ack_seen && (sync2_ff.par != par_expect); // [RULE_13]
  // limit zero fails at once, limit n accepts n wait states
  assign expired = in_wait && !sync2_ff.ack &&
                   (cnt_ff >= ack_wait_limit_ff); // [RULE_02] [RULE_03] [RULE_04]
  assign start_ok = txn_req && (state_ff == dli_pkg::ST_IDLE) &&
                    link_enable_ff && !error_summary_flag_ff;
  // a pending summary flag turns the request into an idle command
  assign start_cancel = txn_req && (state_ff == dli_pkg::ST_IDLE) &&
                        link_enable_ff && error_summary_flag_ff; // [RULE_10]

  // ==========================================================
  // error flag set and clear terms
  wire logic clr_err;
  wire logic any_cause;

  // write 1 to the summary bit clears it and all causes
  assign clr_err = wr_lo && sel_stat0 && pwdata[dli_pkg::BIT_SUMMARY]; // [RULE_07] [RULE_08]
  assign any_cause = data_bad | par_bad | expired | start_cancel |
                     (ack_seen && sync2_ff.err);

  // ==========================================================
  // transaction sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      dli_pkg::ST_IDLE: begin
        nxt_cnt = 4'h0;
        if (start_ok) begin
          nxt_state = dli_pkg::ST_XFER;
        end
      end
      dli_pkg::ST_XFER: begin
        if (link_tick) begin
          if (cnt_ff == dli_pkg::XFER_CYCLES_M1) begin
            nxt_state = dli_pkg::ST_WAIT;
            nxt_cnt = 4'h0;
          end else begin
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
      end
      dli_pkg::ST_WAIT: begin
        if (ack_seen || expired) begin
          nxt_state = dli_pkg::ST_IDLE;
          nxt_cnt = 4'h0;
        end else if (link_tick) begin
          nxt_cnt = cnt_ff + 4'h1; // [RULE_02]
        end
      end
      default: begin
        nxt_state = dli_pkg::ST_IDLE;
        nxt_cnt = 4'h0;
      end
    endcase
  end

  // ==========================================================
  // two-flop synchroniser for all link inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= link_in;
      sync2_ff <= sync1_ff;
    end
  end

  // link clock divider, high for one bus clock out of four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'h0;
      link_clock_ff <= 1'b0;
    end else begin
      div_ff <= link_enable_ff ? div_ff + 2'h1 : 2'h0;
      link_clock_ff <= link_enable_ff && (div_ff < dli_pkg::LINK_HIGH_END);
    end
  end

  // sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= dli_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // control registers with write-once fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_enable_ff <= dli_pkg::RST_CTL0[dli_pkg::BIT_LINK_EN];
      ext_irq_enable_ff <= dli_pkg::RST_CTL1[dli_pkg::BIT_IRQ_EN];
      ack_wait_limit_ff <= dli_pkg::RST_CTL1[3:0];
    end else begin
      if (wr_lo && sel_ctl0 && cfg_open) begin
        link_enable_ff <= pwdata[dli_pkg::BIT_LINK_EN]; // [RULE_19]
      end
      if (wr_lo && sel_ctl1) begin
        ext_irq_enable_ff <= pwdata[dli_pkg::BIT_IRQ_EN]; // [RULE_01]
      end
      if (wr_lo && sel_ctl1 && cfg_open) begin
        ack_wait_limit_ff <= pwdata[3:0]; // [RULE_05]
      end
    end
  end

  // error causes: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_summary_flag_ff <= dli_pkg::RST_STAT0[dli_pkg::BIT_SUMMARY];
      ack_line_fault_flag_ff <= dli_pkg::RST_STAT0[dli_pkg::BIT_ACK_FAULT];
      cancel_flag_ff <= dli_pkg::RST_STAT0[dli_pkg::BIT_CANCEL];
      wait_expired_flag_ff <= dli_pkg::RST_STAT0[dli_pkg::BIT_EXPIRED];
      target_error_flag_ff <= dli_pkg::RST_STAT0[dli_pkg::BIT_TGT_ERR];
      parity_fault_flag_ff <= dli_pkg::RST_STAT0[dli_pkg::BIT_PAR_FAULT];
    end else begin
      error_summary_flag_ff <= any_cause ||
                               (error_summary_flag_ff && !clr_err); // [RULE_06]
      ack_line_fault_flag_ff <= data_bad ||
                                (ack_line_fault_flag_ff && !clr_err); // [RULE_09]
      cancel_flag_ff <= start_cancel ||
                        (cancel_flag_ff && !clr_err); // [RULE_10]
      wait_expired_flag_ff <= expired ||
                              (wait_expired_flag_ff && !clr_err); // [RULE_11]
      target_error_flag_ff <= (ack_seen && sync2_ff.err) ||
                              (target_error_flag_ff && !clr_err); // [RULE_12]
      parity_fault_flag_ff <= par_bad ||
                              (parity_fault_flag_ff && !clr_err); // [RULE_13]
    end
  end

  // received parity kept from the last acknowledge cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      received_par_ff <= dli_pkg::RST_STAT0[1:0];
    end else if (ack_seen) begin
      received_par_ff <= sync2_ff.par; // [RULE_14]
    end
  end

  // event pulses toward the user side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cmd_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      idle_cmd_ff <= start_cancel; // [RULE_10]
      done_ff <= ack_seen || expired;
    end
  end

  // ==========================================================
  // read data
  wire logic [7:0] ctl0_rd;
  wire logic [7:0] ctl1_rd;
  wire logic [7:0] stat0_rd;
  wire logic [7:0] stat1_rd;
  wire logic [7:0] rd_mux;

  assign ctl0_rd = {link_enable_ff, 7'h00};
  assign ctl1_rd = {ext_irq_enable_ff, 3'h0, ack_wait_limit_ff}; // [RULE_18]
  assign stat0_rd = {error_summary_flag_ff, ack_line_fault_flag_ff,
                     cancel_flag_ff, wait_expired_flag_ff,
                     target_error_flag_ff, parity_fault_flag_ff,
                     received_par_ff}; // [RULE_14]
  assign stat1_rd = {sync2_ff.irq, initiator_active, 6'h00}; // [RULE_15] [RULE_17]
  assign rd_mux = sel_ctl0 ? ctl0_rd :
                  sel_ctl1 ? ctl1_rd :
                  sel_stat0 ? stat0_rd :
                  sel_stat1 ? stat1_rd : 8'h00;

  // read data and error registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      pslverr_ff <= !idx_hit;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = rd_acc ? prdata_ff : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = acc_phase && pslverr_ff;
  assign link_clock_pin = link_clock_ff;
  assign idle_cmd_sent = idle_cmd_ff;
  assign txn_done = done_ff;
  assign initiator_active = (state_ff != dli_pkg::ST_IDLE); // [RULE_17]
  // summary flag has no mask, the external one is gated
  assign cpu_irq = error_summary_flag_ff ||
                   (sync2_ff.irq && ext_irq_enable_ff); // [RULE_20] [RULE_01]

endmodule : dli_status
`default_nettype wire

// ---- dli_pkg.sv ----
// package: register map, field layout and link types of the link initiator
// Operation
// [RULE_01] control 1 bit 7 gates the external interrupt from the target
// [RULE_02] after last transfer cycle count link clocks against 4-bit wait limit
// [RULE_03] wait limit zero: acknowledge expected right after last transfer cycle
// [RULE_04] nonzero limit: accept up to that many wait states, then timeout
// [RULE_05] wait limit write-once after link enable in normal mode only
// [RULE_06] status 0 bit 7 summarises the five error causes, unmasked
// [RULE_07] writing 1 clears the error summary flag, 0 leaves it
// [RULE_08] cause flags are read-only, cleared only with the summary flag
// [RULE_09] bit 6 set when data inputs not all high in acknowledge cycle
// [RULE_10] pending summary cancels a new transaction, sends idle, sets bit 5
// [RULE_11] bit 4 set on acknowledge timeout
// [RULE_12] bit 3 set when target signals error in acknowledge cycle
// [RULE_13] bit 2 set on received parity mismatch
// [RULE_14] status 0 bits 1:0 show the two parity bits as received
// [RULE_15] status 1 bit 7 follows the external interrupt pin level
// [RULE_16] target holds its interrupt until its own acknowledge sequence
// [RULE_17] status 1 bit 6 reads 1 while a transaction is in progress
// [RULE_18] control 1 bits 6 to 4 read as zero
// [RULE_19] link enable write-once in normal mode, freezes write-once fields
// [RULE_20] interrupt request on summary flag or enabled external interrupt
package dli_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTL0 = 8'h00;
  localparam logic [7:0] IDX_CTL1 = 8'h01;
  localparam logic [7:0] IDX_STAT0 = 8'h02;
  localparam logic [7:0] IDX_STAT1 = 8'h03;

  // ==========================================================
  // field positions
  localparam int BIT_LINK_EN = 7;
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_SUMMARY = 7;
  localparam int BIT_ACK_FAULT = 6;
  localparam int BIT_CANCEL = 5;
  localparam int BIT_EXPIRED = 4;
  localparam int BIT_TGT_ERR = 3;
  localparam int BIT_PAR_FAULT = 2;
  localparam int BIT_EXT_IRQ = 7;
  localparam int BIT_ACTIVE = 6;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [7:0] RST_STAT0 = 8'h00;

  // ==========================================================
  // timing: link clock period in bus clocks, transfer length in link clocks
  localparam logic [1:0] LINK_DIV_M1 = 2'h3;
  localparam logic [1:0] LINK_HIGH_END = 2'h1;
  localparam logic [3:0] XFER_CYCLES_M1 = 4'h3;

  // ==========================================================
  // link pins as seen by the initiator
  typedef struct packed {
    logic irq;
    logic ack;
    logic err;
    logic [7:0] data;
    logic [1:0] par;
  } dli_link_in_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_WAIT = 2'b10
  } dli_state_t;

endpackage : dli_pkg

// ---- dli_status_monitor.sv ----
// checker: port-level properties of the link initiator status block
`timescale 1ns/1ps
`default_nettype none
module dli_status_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic special_mode,
  input wire logic txn_req,
  input wire dli_pkg::dli_link_in_t link_in,
  input wire logic link_clock_pin,
  input wire logic idle_cmd_sent,
  input wire logic txn_done,
  input wire logic initiator_active,
  input wire logic cpu_irq
);
  // ====================
  // common clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // named steps
  sequence rd_s(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence wr_sum_s(logic b);
    psel && penable && pwrite && pstrb[0] && paddr == 8'h08 && pwdata[7] == b;
  endsequence
  sequence quiet_s;
    !link_in.irq [*3];
  endsequence
  // ====================
  // properties
  rsvd_zero_a:
    assert property (rd_s(8'h04) |-> prdata[6:4] == 3'h0)
    else $error("reserved control bits read nonzero");
  sum_irq_a:
    assert property (quiet_s ##0 rd_s(8'h08) |-> prdata[7] == cpu_irq)
    else $error("interrupt request differs from summary flag");
  pin_mirror_a:
    assert property ($stable(link_in.irq) [*3] ##0 rd_s(8'h0c)
      |-> prdata[7] == link_in.irq)
    else $error("interrupt flag does not follow pin");
  busy_read_a:
    assert property (rd_s(8'h0c) |-> prdata[6] == $past(initiator_active))
    else $error("busy bit differs from activity");
  done_bound_a:
    assert property ($rose(initiator_active) |-> ##[1:120] txn_done)
    else $error("transaction never ended");
  cancel_sum_a:
    assert property (idle_cmd_sent |-> !initiator_active ##[0:2] cpu_irq)
    else $error("cancel without summary flag");
  summary_or_a:
    assert property (rd_s(8'h08) |-> prdata[7] || prdata[6:2] == 5'h00)
    else $error("cause flag set without summary");
  clear_one_a:
    assert property (quiet_s ##0 wr_sum_s(1'b1)
      |=> !cpu_irq || txn_done || idle_cmd_sent)
    else $error("summary not cleared by one");
  keep_zero_a:
    assert property (quiet_s ##0 wr_sum_s(1'b0) ##0 cpu_irq |=> cpu_irq)
    else $error("summary cleared by zero");
endmodule : dli_status_monitor
bind dli_status dli_status_monitor i_dli_status_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .special_mode(special_mode), .txn_req(txn_req), .link_in(link_in),
  .link_clock_pin(link_clock_pin), .idle_cmd_sent(idle_cmd_sent),
  .txn_done(txn_done), .initiator_active(initiator_active),
  .cpu_irq(cpu_irq)
);
`default_nettype wire

// ---- dli_target_model.sv ----
// partner: target die answering the initiator on the link
`timescale 1ns/1ps
`default_nettype none
module dli_target_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_clock_pin,
  input wire logic initiator_active,
  input wire logic irq_hold,
  input wire logic [4:0] waits,
  input wire logic [7:0] ack_data,
  input wire logic ack_err,
  input wire logic par_flip,
  output var dli_pkg::dli_link_in_t link_out
);
  logic lc_ff;
  logic [5:0] rises_ff;
  logic [7:0] pat_ff;
  logic ack_on;
  logic [1:0] par;
  // ====================
  // count link clock rises while a transaction runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_ff <= 1'b0;
      rises_ff <= 6'h00;
      pat_ff <= 8'h00;
    end else begin
      lc_ff <= link_clock_pin;
      pat_ff <= pat_ff + 8'h35; // undriven lines keep changing
      if (!initiator_active)
        rises_ff <= 6'h00;
      else if (link_clock_pin && !lc_ff)
        rises_ff <= rises_ff + 6'h01;
    end
  end
  // ====================
  // acknowledge after the chosen wait states, held until the end
  assign ack_on = initiator_active && rises_ff >= 6'h03 + {1'b0, waits};
  assign par = {^ack_data[7:4], ^ack_data[3:0]} ^ {2{par_flip}};
  // irq held until the tb ends it; error only in acknowledge
  assign link_out = '{irq: irq_hold, ack: ack_on, err: ack_on && ack_err,
    data: ack_on ? ack_data : pat_ff, par: ack_on ? par : pat_ff[1:0]};
endmodule : dli_target_model
`default_nettype wire

// ---- dli_status_test.sv ----
// testbench: registers, link answers and interrupts of the initiator
`timescale 1ns/1ps
`default_nettype none
module dli_status_test;
  localparam logic [7:0] A0 = dli_pkg::IDX_CTL0 << 2;
  localparam logic [7:0] A1 = dli_pkg::IDX_CTL1 << 2;
  localparam logic [7:0] A2 = dli_pkg::IDX_STAT0 << 2;
  localparam logic [7:0] A3 = dli_pkg::IDX_STAT1 << 2;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, special_mode = 1'b0, txn_req = 1'b0, fin = 1'b0;
  logic irq_hold = 1'b0, ack_err = 1'b0, par_flip = 1'b0;
  logic [4:0] waits = 5'h00;
  logic [7:0] paddr = 8'h00, ack_data = 8'hff, r;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, link_clock_pin, idle_cmd_sent, txn_done;
  logic initiator_active, cpu_irq;
  logic [1:0] pb;
  logic [4:0] fl;
  logic [7:0] td [4] = '{8'hff, 8'h5a, 8'hff, 8'hff};
  logic [1:0] tf [4] = '{2'b00, 2'b00, 2'b10, 2'b01};
  dli_pkg::dli_link_in_t link_in;
  logic [31:0] q [$];
  int fails = 0, total_checks = 0, cyc = 0;
  integer seed = 32'he493;

  always #4 pclk = ~pclk;

  dli_status i_dli_status (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .txn_req(txn_req), .link_in(link_in),
    .link_clock_pin(link_clock_pin), .idle_cmd_sent(idle_cmd_sent),
    .txn_done(txn_done), .initiator_active(initiator_active),
    .cpu_irq(cpu_irq));
  dli_target_model i_dli_target_model (.pclk(pclk), .presetn(presetn),
    .link_clock_pin(link_clock_pin), .initiator_active(initiator_active),
    .irq_hold(irq_hold), .waits(waits), .ack_data(ack_data),
    .ack_err(ack_err), .par_flip(par_flip), .link_out(link_in));

  // ====================
  // comparison, verdict and hang guard
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  // read data is compared against the oldest noted value
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready) chk(prdata, q.pop_front());
  // end of a transaction: done or cancelled
  always @(posedge pclk)
    fin <= txn_req ? 1'b0 : fin | txn_done | idle_cmd_sent;

  // ====================
  // bus and link drivers
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) q.push_back({24'h0, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? {24'h0, d} : $random(seed);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk(pslverr, a > A3); // unmapped place answers with error
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task txn(input logic [4:0] w, input logic [7:0] busy);
    waits <= w;
    @(posedge pclk);
    txn_req <= 1'b1;
    @(posedge pclk);
    txn_req <= 1'b0;
    acc(1'b0, A3, busy);
    do @(posedge pclk); while (fin !== 1'b1);
  endtask : txn

  // ====================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, A0, 8'h00);
    acc(0, A1, 8'h00);
    acc(0, A2, 8'h00);
    acc(0, A3, 8'h00);
    acc(0, 8'h10, 8'h00);
    repeat (3) begin
      r = $random(seed);
      acc(1, A1, r);
      acc(0, A1, r & 8'h8f);
    end
    acc(1, A1, 8'h0f);
    acc(1, A0, 8'h80);
    acc(1, A1, 8'h03);
    acc(1, A0, 8'h00);
    acc(0, A1, 8'h0f);
    acc(0, A0, 8'h80);
    pb = 2'h0;
    repeat (4) begin
      @(posedge pclk);
      pb = pb + {1'b0, link_clock_pin};
    end
    chk(pb, 2'h1);
    acc(1, A1, 8'h8f);
    irq_hold <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(cpu_irq, 1'b1);
    acc(0, A3, 8'h80);
    acc(1, A1, 8'h0f);
    @(posedge pclk);
    chk(cpu_irq, 1'b0);
    irq_hold <= 1'b0;
    repeat (4) @(posedge pclk);
    acc(0, A3, 8'h00);
    txn(5'h05, 8'h40);
    acc(0, A2, 8'h00);
    special_mode <= 1'b1;
    acc(1, A1, 8'h00);
    acc(0, A1, 8'h00);
    acc(1, A0, 8'h00);
    acc(0, A0, 8'h00);
    acc(1, A0, 8'h80);
    acc(0, A0, 8'h80);
    pstrb <= 4'he;
    acc(1, A1, 8'h05);
    pstrb <= 4'hf;
    acc(0, A1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ack_data <= td[i];
      {ack_err, par_flip} <= tf[i];
      txn(5'h00, 8'h40);
      pb = {^td[i][7:4], ^td[i][3:0]} ^ {2{tf[i][0]}};
      fl = {td[i] != 8'hff, 2'b00, tf[i]};
      acc(0, A2, {|fl, fl, pb});
      acc(1, A2, 8'h7f);
      acc(0, A2, {|fl, fl, pb});
      acc(1, A2, 8'h80);
      acc(0, A2, {6'h00, pb});
    end
    acc(1, A1, 8'h02);
    txn(5'h1f, 8'h40);
    acc(0, A2, 8'h93);
    txn(5'h00, 8'h00);
    acc(0, A2, 8'hb3);
    acc(1, A2, 8'h80);
    acc(0, A2, 8'h03);
    tally_and_finish;
  end
endmodule : dli_status_test
`default_nettype wire
